// File: dcip_input_port.sv
// Channel data input port: data clock, symbol request, word reassembly
`timescale 1ns/1ps
module dcip_input_port (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Straps
  input wire logic i_bus_type_strap,
  input wire logic i_ctrl_type_strap,
  // Data pins
  input wire logic [31:0] i_cmos_data,
  input wire logic [15:0] i_lvds_data,
  input wire logic i_parity_bit_low,
  input wire logic i_parity_bit_high,
  input wire logic i_parity_pair_pos,
  // Clock and request pins
  output logic o_single_ended_data_clock,
  output logic o_single_ended_symbol_request,
  output logic o_data_clock_pos,
  output logic o_data_clock_neg,
  output logic o_symbol_request_pos,
  output logic o_symbol_request_neg,
  // Symbol pacing from the rate converter
  input wire logic i_symbol_tick,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wr_data,
  output logic [7:0] o_reg_rd_data,
  // Word stream toward the datapath
  output logic o_word_valid,
  output dcip_pkg::dcip_word_s o_word,
  input wire logic i_word_ready
);

  dcip_pkg::dcip_state_s s;
  dcip_pkg::dcip_state_s n;

  // Index of the k-th enabled channel when packing is on
  function automatic logic [1:0] nth_chan(input logic [3:0] en,
                                          input logic [1:0] k);
    logic [2:0] seen;
    logic [1:0] r;
    seen = 3'h0;
    r = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (en[i]) begin
        if (seen == {1'b0, k}) r = 2'(i);
        seen = seen + 3'h1;
      end
    end
    return r;
  endfunction

  logic [1:0] bw_code;
  logic dw16;
  logic cplx;
  logic ddr;
  logic [2:0] slots;
  logic [3:0] words;
  logic [7:0] bits;
  logic [7:0] bw;
  logic [2:0] bw_sh;
  logic [2:0] dw_sh;
  logic [7:0] xfers;
  logic a_mode;
  logic [1:0] per_x;
  logic [1:0] need;
  logic dclk_on;
  logic [6:0] period;
  logic [6:0] half;
  logic rise;
  logic fall;
  logic [31:0] cap;
  logic [31:0] shifted;
  logic [15:0] new_acc;
  logic [1:0] slot;
  logic keep;
  logic push;
  logic pop;
  dcip_pkg::dcip_word_s w;

  always_comb begin
    n = s;
    // Pin synchronisers; muxing sits before the first stage
    n.sync1_data = s.bus_cmos ? i_cmos_data : {16'h0000, i_lvds_data};
    n.sync2_data = s.sync1_data;
    n.sync1_par = {i_parity_pair_pos, i_parity_bit_high, i_parity_bit_low};
    n.sync2_par = s.sync1_par;
    n.sync1_strap = {i_ctrl_type_strap, i_bus_type_strap};
    n.sync2_strap = s.sync1_strap;

    // Straps are caught once the synchroniser has filled
    if (!s.strap_ok) begin
      n.strap_age = s.strap_age + 2'h1;
      if (s.strap_age == dcip_pkg::STRAP_SETTLE) begin
        n.strap_ok = 1'b1;
        n.bus_cmos = s.sync2_strap[0];
        n.ctrl_cmos = s.sync2_strap[1];
      end
    end

    // Effective format; upconverter mode overrides the fields
    bw_code = s.upconv ? dcip_pkg::BW_32 : s.bw_code;
    dw16 = s.upconv | s.dw16;
    cplx = s.upconv | s.cplx;
    ddr = !s.bus_cmos && (bw_code == dcip_pkg::BW_32);
    if (s.upconv) slots = 3'h1;
    else if (s.prio) slots = 3'h4;
    else slots = {2'b00, s.chen[0]} + {2'b00, s.chen[1]}
               + {2'b00, s.chen[2]} + {2'b00, s.chen[3]};
    words = cplx ? {slots, 1'b0} : {1'b0, slots};
    bits = dw16 ? {words, 4'h0} : {1'b0, words, 3'h0};
    bw_sh = {1'b0, bw_code} + 3'h2;
    bw = 8'h01 << bw_sh;
    dw_sh = dw16 ? 3'h4 : 3'h3;
    xfers = (bits + bw - 8'h01) >> bw_sh;
    a_mode = bw_sh >= dw_sh;
    per_x = a_mode ? 2'((4'h1 << (bw_sh - dw_sh)) - 4'h1) : 2'h0;
    need = a_mode ? 2'h0 : 2'((4'h1 << (dw_sh - bw_sh)) - 4'h1);

    // Data clock divider; 0, 3 and 5 to 7 leave the clock off
    dclk_on = (s.div == 3'h1) || (s.div == 3'h2) || (s.div == 3'h4);
    period = {4'h0, s.div} * 7'(dcip_pkg::DATA_CLK_BASE_DIV);
    half = {1'b0, s.div, 3'h0};
    rise = dclk_on && (s.cnt == 7'h00);
    fall = dclk_on && (s.cnt == half);
    if (!dclk_on || s.cnt == period - 7'h01) n.cnt = 7'h00;
    else n.cnt = s.cnt + 7'h01;
    n.dclk = dclk_on && (s.cnt < half);

    // Register writes and clear-on-write-one status
    if (i_reg_wr_en) begin
      case (i_reg_addr)
        dcip_pkg::ADDR_MODE: begin
          n.upconv = i_reg_wr_data[dcip_pkg::MODE_QUAD_BIT];
          n.prio = i_reg_wr_data[dcip_pkg::MODE_PRIO_BIT];
        end
        dcip_pkg::ADDR_IFCFG: begin
          n.bw_code = i_reg_wr_data[dcip_pkg::IF_BW_LSB +: 2];
          n.dw16 = i_reg_wr_data[dcip_pkg::IF_DW_BIT];
          n.cplx = i_reg_wr_data[dcip_pkg::IF_CPLX_BIT];
        end
        dcip_pkg::ADDR_CLKDIV: n.div = i_reg_wr_data[dcip_pkg::DIV_LSB +: 3];
        dcip_pkg::ADDR_CHEN: n.chen = i_reg_wr_data[3:0];
        dcip_pkg::ADDR_STATUS: begin
          if (i_reg_wr_data[dcip_pkg::ST_OVR_BIT]) n.ovr = 1'b0;
          if (i_reg_wr_data[dcip_pkg::ST_PAR_BIT]) n.par_err = 1'b0;
        end
        default: ;
      endcase
    end

    // Pending symbol; a tick in the issuing cycle is kept
    if (s.phase == dcip_pkg::ST_IDLE && rise && s.pend && words != 4'h0
        && s.fcnt == 2'h0 && !s.emit_v && !s.xfer_v) begin
      n.pend = 1'b0;
      n.phase = dcip_pkg::ST_REQ;
      n.xfer_cnt = 8'h00;
    end
    if (i_symbol_tick) n.pend = 1'b1;

    // Buffer: head pops on ready, emitted word pushes when room
    pop = (s.fcnt != 2'h0) && i_word_ready;
    keep = !(s.prio && !s.upconv && !s.chen[s.emit.chan]);
    push = s.emit_v && keep && (s.fcnt != 2'h2);
    if (s.emit_v && (!keep || push)) n.emit_v = 1'b0;
    if (pop) begin
      n.fifo0 = s.fifo1;
      n.fcnt = s.fcnt - 2'h1;
    end
    if (push) begin
      if (n.fcnt == 2'h0) n.fifo0 = s.emit;
      else n.fifo1 = s.emit;
      n.fcnt = n.fcnt + 2'h1;
    end

    // Unpacker: one channel word per cycle from the held transfer
    slot = cplx ? s.word_ix[2:1] : s.word_ix[1:0];
    w.chan = (s.prio || s.upconv) ? slot : nth_chan(s.chen, slot);
    w.quad = cplx & s.word_ix[0];
    shifted = s.xfer >> ({3'h0, s.sub} << dw_sh);
    w.data = dw16 ? shifted[15:0] : {8'h00, shifted[7:0]};
    new_acc = (bw_code == 2'h0) ? {s.acc[11:0], s.xfer[3:0]}
                                : {s.acc[7:0], s.xfer[7:0]};
    if (s.xfer_v && !n.emit_v) begin
      if (s.word_ix >= words) begin
        n.xfer_v = 1'b0;
      end else if (a_mode) begin
        n.emit = w;
        n.emit_v = 1'b1;
        n.word_ix = s.word_ix + 4'h1;
        if (s.sub == per_x || s.word_ix + 4'h1 == words) begin
          n.sub = 2'h0;
          n.xfer_v = 1'b0;
        end else begin
          n.sub = s.sub + 2'h1;
        end
      end else begin
        n.acc = new_acc;
        n.xfer_v = 1'b0;
        if (s.piece == need) begin
          n.emit = w;
          n.emit.data = dw16 ? new_acc : {8'h00, new_acc[7:0]};
          n.emit_v = 1'b1;
          n.word_ix = s.word_ix + 4'h1;
          n.piece = 2'h0;
        end else begin
          n.piece = s.piece + 2'h1;
        end
      end
    end

    // Request and capture sequence
    cap = ddr ? {s.sync2_data[15:0], s.lo} : s.sync2_data;
    case (s.phase)
      dcip_pkg::ST_IDLE: ;
      dcip_pkg::ST_REQ: begin
        n.word_ix = 4'h0;
        n.sub = 2'h0;
        n.piece = 2'h0;
        if (rise) begin
          n.phase = dcip_pkg::ST_COLLECT;
        end
      end
      dcip_pkg::ST_COLLECT: begin
        // Synchronised pins lag, so each half is taken late in its phase
        if (fall && ddr) n.lo = s.sync2_data[15:0];
        if (ddr ? rise : fall) begin
          // Single rate completes on the fall, double rate on the rise
          if (n.xfer_v) n.ovr = 1'b1;
          n.xfer = cap;
          n.xfer_v = 1'b1;
          if (bw_code[1]) begin
            if (s.bus_cmos) begin
              if (^cap[15:0] != s.sync2_par[0]) n.par_err = 1'b1;
              if (bw_code == dcip_pkg::BW_32 &&
                  ^cap[31:16] != s.sync2_par[1]) n.par_err = 1'b1;
            end else if (^s.sync2_data[15:0] != s.sync2_par[2]) begin
              n.par_err = 1'b1;
            end
          end
          n.xfer_cnt = s.xfer_cnt + 8'h01;
          if (s.xfer_cnt + 8'h01 >= xfers) n.phase = dcip_pkg::ST_IDLE;
        end
      end
      default: n.phase = dcip_pkg::ST_IDLE;
    endcase
    // Follows the next phase so the pin rises with the data clock pin
    n.req_pin = (n.phase == dcip_pkg::ST_REQ);

    // Registered read data
    case (i_reg_addr)
      dcip_pkg::ADDR_MODE:
        n.rd_data = {4'h0, s.upconv, s.prio, 2'h0};
      dcip_pkg::ADDR_IFCFG:
        n.rd_data = {1'b0, s.bw_code, s.dw16, s.cplx, 3'h0};
      dcip_pkg::ADDR_CLKDIV: n.rd_data = {1'b0, s.div, 4'h0};
      dcip_pkg::ADDR_CHEN: n.rd_data = {4'h0, s.chen};
      dcip_pkg::ADDR_STATUS:
        n.rd_data = {5'h00, s.phase != dcip_pkg::ST_IDLE, s.par_err, s.ovr};
      default: n.rd_data = 8'h00;
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s <= '0;
      s.upconv <= dcip_pkg::MODE_RST[dcip_pkg::MODE_QUAD_BIT];
      s.prio <= dcip_pkg::MODE_RST[dcip_pkg::MODE_PRIO_BIT];
      s.bw_code <= dcip_pkg::IFCFG_RST[dcip_pkg::IF_BW_LSB +: 2];
      s.dw16 <= dcip_pkg::IFCFG_RST[dcip_pkg::IF_DW_BIT];
      s.cplx <= dcip_pkg::IFCFG_RST[dcip_pkg::IF_CPLX_BIT];
      s.div <= dcip_pkg::CLKDIV_RST[dcip_pkg::DIV_LSB +: 3];
      s.chen <= dcip_pkg::CHEN_RST[3:0];
      s.phase <= dcip_pkg::ST_IDLE;
    end else begin
      s <= n;
    end
  end

  // Pin drive chosen by the caught control strap, pair drive until then; unused pins stay low
  assign o_single_ended_data_clock = s.ctrl_cmos & s.dclk;
  assign o_single_ended_symbol_request = s.ctrl_cmos & s.req_pin;
  assign o_data_clock_pos = !s.ctrl_cmos & s.dclk;
  assign o_data_clock_neg = !s.ctrl_cmos & !s.dclk;
  assign o_symbol_request_pos = !s.ctrl_cmos & s.req_pin;
  assign o_symbol_request_neg = !s.ctrl_cmos & !s.req_pin;
  assign o_reg_rd_data = s.rd_data;
  assign o_word_valid = s.fcnt != 2'h0;
  assign o_word = s.fifo0;

endmodule

// File: dcip_pkg.sv
// Constants and types for the channel data input port
package dcip_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_MODE = 8'h20;
  localparam logic [7:0] ADDR_IFCFG = 8'h21;
  localparam logic [7:0] ADDR_CLKDIV = 8'h22;
  localparam logic [7:0] ADDR_CHEN = 8'h2e;
  localparam logic [7:0] ADDR_STATUS = 8'h2f;
  // Field positions
  localparam int MODE_QUAD_BIT = 3;
  localparam int MODE_PRIO_BIT = 2;
  localparam int IF_BW_LSB = 5;
  localparam int IF_DW_BIT = 4;
  localparam int IF_CPLX_BIT = 3;
  localparam int DIV_LSB = 4;
  localparam int ST_OVR_BIT = 0;
  localparam int ST_PAR_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IFCFG_RST = 8'h00;
  localparam logic [7:0] CLKDIV_RST = 8'h10;
  localparam logic [7:0] CHEN_RST = 8'h0f;
  // Timing: data clock is converter clock / (16 * divider)
  localparam int DATA_CLK_BASE_DIV = 16;
  localparam int CHANZ_RATE_DIV = 48;
  localparam int QUAD_RATE_DIV = 16;
  localparam logic [1:0] BW_32 = 2'h3;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_COLLECT} dcip_phase_e;

  // One reassembled channel word, LSB justified
  typedef struct packed {
    logic [1:0] chan;
    logic quad;
    logic [15:0] data;
  } dcip_word_s;

  // Whole state of the port
  typedef struct packed {
    logic [31:0] sync1_data;
    logic [31:0] sync2_data;
    logic [2:0] sync1_par;
    logic [2:0] sync2_par;
    logic [1:0] sync1_strap;
    logic [1:0] sync2_strap;
    logic [1:0] strap_age;
    logic strap_ok;
    logic bus_cmos;
    logic ctrl_cmos;
    logic upconv;
    logic prio;
    logic [1:0] bw_code;
    logic dw16;
    logic cplx;
    logic [2:0] div;
    logic [3:0] chen;
    logic ovr;
    logic par_err;
    logic [7:0] rd_data;
    logic [6:0] cnt;
    logic dclk;
    logic req_pin;
    logic pend;
    dcip_phase_e phase;
    logic [7:0] xfer_cnt;
    logic [15:0] lo;
    logic [31:0] xfer;
    logic xfer_v;
    logic [1:0] sub;
    logic [1:0] piece;
    logic [15:0] acc;
    logic [3:0] word_ix;
    logic emit_v;
    dcip_word_s emit;
    dcip_word_s fifo0;
    dcip_word_s fifo1;
    logic [1:0] fcnt;
  } dcip_state_s;
endpackage

// File: dcip_input_port_chk.sv
// Timing checks on the pins of the channel data input port
`timescale 1ns/1ps
module dcip_chk (
  // Clock, reset, strap
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ctrl_type_strap,
  // Register writes
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wr_data,
  // Clock and request pins
  input wire logic o_single_ended_data_clock,
  input wire logic o_single_ended_symbol_request,
  input wire logic o_data_clock_pos,
  input wire logic o_data_clock_neg,
  input wire logic o_symbol_request_pos,
  input wire logic o_symbol_request_neg,
  // Word stream
  input wire logic o_word_valid,
  input wire dcip_pkg::dcip_word_s o_word,
  input wire logic i_word_ready
);
  logic dk;
  logic rq;
  logic ok;
  logic [2:0] dv_q;
  logic [6:0] hi_q;
  logic [6:0] lo_q;
  logic [6:0] rh_q;
  logic [6:0] age_q;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // Active pin flavour; strap changes only under reset
  assign dk = i_ctrl_type_strap ? o_single_ended_data_clock : o_data_clock_pos;
  assign rq = i_ctrl_type_strap ? o_single_ended_symbol_request :
              o_symbol_request_pos;
  assign ok = &age_q;
  // Run lengths; age restarts on reset or divider write, masking old periods
  always_ff @(posedge i_sys_clk) begin
    hi_q <= dk ? hi_q + 7'h1 : 7'h0;
    lo_q <= dk ? 7'h0 : lo_q + 7'h1;
    rh_q <= rq ? rh_q + 7'h1 : 7'h0;
    if (i_srst) begin
      dv_q <= 3'h1;
      age_q <= 7'h0;
    end else if (i_reg_wr_en && i_reg_addr == dcip_pkg::ADDR_CLKDIV) begin
      dv_q <= i_reg_wr_data[6:4];
      age_q <= 7'h0;
    end else if (!ok) begin
      age_q <= age_q + 7'h1;
    end
  end
  chk_pairs_quiet: assert property (
    ok && i_ctrl_type_strap |-> !(o_data_clock_pos || o_data_clock_neg ||
    o_symbol_request_pos || o_symbol_request_neg))
    else $error("pair pins active in single-ended mode");
  chk_single_quiet: assert property (
    ok && !i_ctrl_type_strap |->
    !(o_single_ended_data_clock || o_single_ended_symbol_request))
    else $error("single-ended pins active in pair mode");
  chk_pair_inverse: assert property (
    ok && !i_ctrl_type_strap |-> o_data_clock_neg != o_data_clock_pos &&
    o_symbol_request_neg != o_symbol_request_pos)
    else $error("pair legs not complementary");
  chk_clock_high: assert property (
    ok && $fell(dk) |-> hi_q == {1'b0, dv_q, 3'h0})
    else $error("data clock high phase length wrong");
  chk_clock_low: assert property (
    ok && $rose(dk) |-> lo_q == {1'b0, dv_q, 3'h0})
    else $error("data clock low phase length wrong");
  chk_req_on_rise: assert property (
    $rose(rq) |-> $rose(dk))
    else $error("request not aligned to data clock rise");
  chk_req_period: assert property (
    ok && $fell(rq) |-> rh_q == {dv_q, 4'h0})
    else $error("request not one data clock period long");
  chk_word_hold: assert property (
    o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
    else $error("word changed or lost while stalled");
endmodule
bind dcip_input_port dcip_chk chk (.*);

// File: dcip_src_model.sv
// Data source model on the far side of the input port
`timescale 1ns/1ps
module dcip_src_model (
  // Clock and strap
  input wire logic i_sys_clk,
  input wire logic i_ctrl_type_strap,
  // Clock and request pins from the port
  input wire logic i_se_clk,
  input wire logic i_se_req,
  input wire logic i_pair_clk,
  input wire logic i_pair_req,
  // Transfers to send per request
  input wire logic [7:0][31:0] i_xfer,
  input wire logic [3:0] i_nx,
  // Data pins toward the port
  output logic [31:0] o_cmos,
  output logic [15:0] o_lvds,
  output logic o_par_lo,
  output logic o_par_hi,
  output logic o_par_pair
);
  logic dk;
  logic rq;
  logic dk_q = 1'b0;
  logic [3:0] left = 4'h0;
  logic [3:0] ix = 4'h0;
  logic [31:0] cur = 32'h0;
  assign dk = i_ctrl_type_strap ? i_se_clk : i_pair_clk;
  assign rq = i_ctrl_type_strap ? i_se_req : i_pair_req;
  // One transfer per clock period after the request; idle bus toggles
  always @(posedge i_sys_clk) begin
    dk_q <= dk;
    if (dk && !dk_q) begin
      cur <= left != 4'h0 ? i_xfer[ix[2:0]] : ~cur;
      ix <= rq ? 4'h0 : ix + 4'h1;
      left <= rq ? i_nx : left - {3'h0, left != 4'h0};
    end
  end
  // Lowest pins carry data; double rate splits halves by phase
  assign o_cmos = cur;
  assign o_lvds = dk ? cur[15:0] : cur[31:16];
  assign o_par_lo = ^cur[15:0];
  assign o_par_hi = ^cur[31:16];
  assign o_par_pair = ^o_lvds;
endmodule

// File: tb_dcip_input_port.sv
// Self-checking bench for the channel data input port
`timescale 1ns/1ps
module tb_dcip_input_port;
  logic clk = 1'b0, srst = 1'b1, bs = 1'b1, cs = 1'b1, tick = 1'b0;
  logic wen = 1'b0, rdy = 1'b1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdd;
  logic [31:0] cm;
  logic [15:0] lv;
  logic pl, ph, pp, sdk, srq, pdk, prq, wv;
  dcip_pkg::dcip_word_s w;
  logic [7:0][31:0] xf = '0;
  logic [3:0] nx = 4'h0;
  int errors = 0, comparisons = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  dcip_input_port uut (
    .i_sys_clk(clk), .i_srst(srst),
    .i_bus_type_strap(bs), .i_ctrl_type_strap(cs),
    .i_cmos_data(cm), .i_lvds_data(lv),
    .i_parity_bit_low(pl), .i_parity_bit_high(ph), .i_parity_pair_pos(pp),
    .o_single_ended_data_clock(sdk), .o_single_ended_symbol_request(srq),
    .o_data_clock_pos(pdk), .o_data_clock_neg(),
    .o_symbol_request_pos(prq), .o_symbol_request_neg(),
    .i_symbol_tick(tick), .i_reg_addr(addr), .i_reg_wr_en(wen),
    .i_reg_wr_data(wd), .o_reg_rd_data(rdd),
    .o_word_valid(wv), .o_word(w), .i_word_ready(rdy));
  dcip_src_model src (
    .i_sys_clk(clk), .i_ctrl_type_strap(cs),
    .i_se_clk(sdk), .i_se_req(srq), .i_pair_clk(pdk), .i_pair_req(prq),
    .i_xfer(xf), .i_nx(nx), .o_cmos(cm), .o_lvds(lv),
    .o_par_lo(pl), .o_par_hi(ph), .o_par_pair(pp));
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rst(input logic b, c);
    @(posedge clk);
    srst <= 1'b1;
    bs <= b;
    cs <= c;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wen <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, exp, input string nm);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1 check(nm, 32'(rdd), 32'(exp));
  endtask
  task automatic t_regs;
    rdchk(8'h20, dcip_pkg::MODE_RST, "mode");
    rdchk(8'h21, dcip_pkg::IFCFG_RST, "ifcfg");
    rdchk(8'h22, dcip_pkg::CLKDIV_RST, "clkdiv");
    rdchk(8'h2e, dcip_pkg::CHEN_RST, "chen");
    rdchk(8'h30, 8'h00, "unmapped");
    wr(8'h21, 8'h78);
    rdchk(8'h21, 8'h78, "ifcfg rw");
  endtask
  task automatic rises(input int len, input int exp);
    int n;
    logic p;
    n = 0;
    #1 p = sdk;
    repeat (len) begin
      @(posedge clk);
      #1 n += int'(sdk && !p);
      p = sdk;
    end
    check("clock rises", n, exp);
  endtask
  task automatic t_clock;
    wr(8'h22, 8'h20);
    repeat (200) @(posedge clk);
    rises(320, 10);
    wr(8'h22, 8'h00);
    repeat (150) @(posedge clk);
    rises(128, 0);
    wr(8'h22, 8'h10);
    repeat (150) @(posedge clk);
  endtask
  // One symbol: build source transfers, request it, judge the words
  task automatic run(input logic [1:0] bc, input logic d16, cx, pr, q,
                     input logic [3:0] en, input int stall);
    int bw, dw, f, k, n, nt;
    logic [15:0] v;
    dcip_pkg::dcip_word_s ex[$], got[$];
    bw = q ? 32 : 4 << bc;
    dw = (q || d16) ? 16 : 8;
    f = (q || cx) ? 2 : 1;
    xf = '0;
    k = 0;
    nt = 0;
    for (int c = 0; c < 4; c++) begin
      if (q ? c == 0 : (pr || en[c])) begin
        for (int h = 0; h < f; h++) begin
          v = 16'h9a5c ^ 16'(k * 16'h1357);
          if (dw == 8) v[15:8] = 8'h00;
          if (q || en[c]) ex.push_back({2'(c), h[0], v});
          if (dw > bw) begin
            // Narrow bus: most significant piece first
            for (int p = 0; p < dw / bw; p++) begin
              xf[nt] = 32'(v >> (dw - bw * (p + 1)));
              xf[nt] = xf[nt] & ~(32'hffffffff << bw);
              nt++;
            end
          end else begin
            n = k / (bw / dw);
            xf[n] |= 32'(v) << (k % (bw / dw) * dw);
            nt = n + 1;
          end
          k++;
        end
      end
    end
    nx <= 4'(nt);
    wr(8'h20, {4'h0, q, pr, 2'h0});
    wr(8'h21, {1'b0, bc, d16, cx, 3'h0});
    wr(8'h2e, {4'h0, en});
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    for (int t = 0; t < 3000 && got.size() < ex.size(); t++) begin
      @(posedge clk);
      rdy <= t >= stall;
      #1 if (wv === 1'b1 && rdy === 1'b1) got.push_back(w);
    end
    check("word count", got.size(), ex.size());
    if (got.size() != ex.size()) print_verdict;
    foreach (ex[i]) check("word", 32'(got[i]), 32'(ex[i]));
    rdchk(8'h2f, {5'h0, 3'bx00} & 8'h03, "status");
  endtask
  initial begin
    rst(1'b1, 1'b1);
    t_regs;
    t_clock;
    run(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf, 0);
    run(2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf, 0);
    run(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 100);
    run(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 0);
    run(2'h2, 1'b0, 1'b1, 1'b0, 1'b0, 4'h5, 0);
    run(2'h3, 1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 0);
    run(2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 0);
    rst(1'b0, 1'b0);
    run(2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 0);
    run(2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 0);
    print_verdict;
  end
endmodule
